/* File: common/pcar_pkg.sv */
// Constants and types of the configuration address router
// Summary of operation
// - Dword-only 32-bit address register, resets to zero
// - Byte or word access passes through as I/O
// - Top bit enables configuration space
// - Bits 30 to 24 read zero
// - Bus zero, device two up: hub
// - Bus equals secondary: graphics Type 0
// - Bus above secondary to highest: graphics Type 1
// - Bus outside graphics range: hub Type 1
// - Bus zero devices 0 and 1 internal
// - Device n asserts ID select bit 16+n
// - Device above 15: no select, master abort
// - Device field copied to address bits 15:11, except graphics Type 0 (bits 15:11 zero)
// - Function field copied to bits 10:8
// - Internal devices ignore nonzero function
// - Register field copied to bits 7:2
// - Enabled data window access becomes configuration
// - Disabled internal device: hub Type 0
package pcar_pkg;
    // ==========================================
    // Ports and register layout
    localparam logic [15:0] CFG_ADDR_PORT  = 16'h0cf8;
    localparam logic [15:0] CFG_DATA_PORT  = 16'h0cfc;
    localparam logic [31:0] CFG_ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h80ff_fffc;
    localparam logic [3:0]  FULL_DWORD     = 4'hf;
    localparam int          ENABLE_BIT     = 31;
    localparam int          BUS_HI         = 23;
    localparam int          BUS_LO         = 16;
    localparam int          DEV_HI         = 15;
    localparam int          DEV_LO         = 11;
    localparam int          FUNC_HI        = 10;
    localparam int          FUNC_LO        = 8;
    localparam int          REG_HI         = 7;
    localparam int          REG_LO         = 2;
    localparam int          IDSEL_BASE     = 16;
    // ==========================================
    // Decode values
    localparam logic [7:0]  BUS_ZERO       = 8'h00;
    localparam logic [4:0]  DEV_HOST_HUB   = 5'h00;
    localparam logic [4:0]  DEV_HOST_GFX   = 5'h01;
    localparam logic [2:0]  FUNC_ZERO      = 3'h0;
    localparam logic [1:0]  TYPE0_CODE     = 2'h0;
    localparam logic [1:0]  TYPE1_CODE     = 2'h1;
    localparam logic [15:0] IDSEL_ONE      = 16'h0001;
    // ==========================================
    // Routing targets
    typedef enum logic [2:0] {
        ROUTE_NONE     = 3'h0,
        ROUTE_INTERNAL = 3'h1,
        ROUTE_IGNORED  = 3'h3,
        ROUTE_HUB_IO   = 3'h2,
        ROUTE_HUB_T0   = 3'h6,
        ROUTE_HUB_T1   = 3'h7,
        ROUTE_GFX_T0   = 3'h5,
        ROUTE_GFX_T1   = 3'h4
    } pcar_route_e;
endpackage

/* File: design/pcar_config_router.sv */
// Configuration address register and configuration cycle router
`timescale 1ns/1ps
module pcar_config_router (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 ioValid,
    input  wire logic                 ioWrite,
    input  wire logic [15:0]          ioAddr,
    input  wire logic [3:0]           ioByteEn,
    input  wire logic [31:0]          ioWdata,
    input  wire logic [7:0]           secondaryBus,
    input  wire logic [7:0]           highestBusIndex,
    input  wire logic                 hostHubEnable,
    input  wire logic                 hostGfxEnable,
    input  wire logic                 masterAbortClr,
    output logic                      ioAck,
    output logic                      ioClaim,
    output logic [31:0]               ioRdata,
    output logic                      cycleValid,
    output pcar_pkg::pcar_route_e     cycleRoute,
    output logic [31:0]               cycleAddr,
    output logic                      cycleWrite,
    output logic [3:0]                cycleByteEn,
    output logic [31:0]               cycleWdata,
    output logic [1:0]                internalSel,
    output logic                      masterAbort
);
    import pcar_pkg::*;

    // ==========================================
    // Address register and field decode
    logic [31:0]  cfgAddr;
    logic         cfgSpaceGate;
    logic [7:0]   busNum;
    logic [4:0]   devNum;
    logic [2:0]   funcNum;
    logic [5:0]   regNum;
    logic         isAddrPort;
    logic         isDataPort;
    logic         fullDword;
    logic         addrWrite;
    logic         devEnabled;
    logic [15:0]  idselLines;

    assign cfgSpaceGate = cfgAddr[ENABLE_BIT];
    assign busNum       = cfgAddr[BUS_HI:BUS_LO];
    assign devNum       = cfgAddr[DEV_HI:DEV_LO];
    assign funcNum      = cfgAddr[FUNC_HI:FUNC_LO];
    assign regNum       = cfgAddr[REG_HI:REG_LO];
    assign isAddrPort   = ioAddr[15:2] == CFG_ADDR_PORT[15:2];
    assign isDataPort   = ioAddr[15:2] == CFG_DATA_PORT[15:2];
    assign fullDword    = ioByteEn == FULL_DWORD;
    assign addrWrite    = ioValid && ioWrite && isAddrPort && fullDword;
    assign devEnabled   = (devNum == DEV_HOST_HUB) ? hostHubEnable : hostGfxEnable;
    assign idselLines   = devNum[4] ? 16'h0000 : (IDSEL_ONE << devNum[3:0]);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfgAddr <= CFG_ADDR_RESET;
        end else if (addrWrite) begin
            cfgAddr <= ioWdata & CFG_WRITE_MASK;
        end
    end

    // ==========================================
    // Route decision
    pcar_route_e  next_route;
    logic [31:0]  next_addr;

    always_comb begin
        next_route = ROUTE_NONE;
        next_addr  = 32'h0000_0000;
        if (ioValid && isAddrPort && !fullDword) begin
            next_route = ROUTE_HUB_IO;
            next_addr  = {16'h0000, ioAddr};
        end else if (ioValid && isDataPort && !cfgSpaceGate) begin
            next_route = ROUTE_HUB_IO;
            next_addr  = {16'h0000, ioAddr};
        end else if (ioValid && isDataPort) begin
            if (busNum == BUS_ZERO) begin
                next_addr = {16'h0000, devNum, funcNum, regNum, TYPE0_CODE};
                if (devNum != DEV_HOST_HUB && devNum != DEV_HOST_GFX) begin
                    next_route = ROUTE_HUB_T0;
                end else if (!devEnabled) begin
                    next_route = ROUTE_HUB_T0;
                end else if (funcNum != FUNC_ZERO) begin
                    next_route = ROUTE_IGNORED;
                end else begin
                    next_route = ROUTE_INTERNAL;
                end
            end else if (busNum == secondaryBus) begin
                next_route = ROUTE_GFX_T0;
                next_addr  = {idselLines, 5'h00, funcNum,
                              regNum, TYPE0_CODE};
            end else if (busNum > secondaryBus && busNum <= highestBusIndex) begin
                next_route = ROUTE_GFX_T1;
                next_addr  = {8'h00, busNum, devNum, funcNum,
                              regNum, TYPE1_CODE};
            end else begin
                next_route = ROUTE_HUB_T1;
                next_addr  = {8'h00, busNum, devNum, funcNum,
                              regNum, TYPE1_CODE};
            end
        end
    end

    // ==========================================
    // Processor answer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ioAck   <= 1'b0;
            ioClaim <= 1'b0;
            ioRdata <= 32'h0000_0000;
        end else begin
            ioAck   <= ioValid;
            ioClaim <= ioValid && isAddrPort && fullDword;
            if (ioValid && !ioWrite && isAddrPort && fullDword) begin
                ioRdata <= cfgAddr;
            end else begin
                ioRdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================
    // Outgoing cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cycleValid  <= 1'b0;
            cycleRoute  <= ROUTE_NONE;
            cycleAddr   <= 32'h0000_0000;
            cycleWrite  <= 1'b0;
            cycleByteEn <= 4'h0;
            cycleWdata  <= 32'h0000_0000;
            internalSel <= 2'b00;
        end else begin
            cycleValid  <= next_route != ROUTE_NONE && next_route != ROUTE_INTERNAL
                           && next_route != ROUTE_IGNORED;
            cycleRoute  <= next_route;
            cycleAddr   <= next_addr;
            cycleWrite  <= ioWrite;
            cycleByteEn <= ioByteEn;
            cycleWdata  <= ioWdata;
            internalSel <= 2'b00;
            if (next_route == ROUTE_INTERNAL) begin
                internalSel[devNum[0]] <= 1'b1;
            end
        end
    end

    // ==========================================
    // Virtual bridge master abort status
    logic abortEvent;
    assign abortEvent = next_route == ROUTE_GFX_T0 && devNum[4];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            masterAbort <= 1'b0;
        end else if (abortEvent) begin
            masterAbort <= 1'b1;
        end else if (masterAbortClr) begin
            masterAbort <= 1'b0;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_cfgAccess;
        ioValid && isDataPort && cfgSpaceGate;
    endsequence

    sequence s_busZeroExternal;
        s_cfgAccess ##0 busNum == BUS_ZERO && devNum > DEV_HOST_GFX;
    endsequence

    sequence s_gfxType0;
        s_cfgAccess ##0 busNum != BUS_ZERO && busNum == secondaryBus;
    endsequence

    property p_addrWrite;
        addrWrite |=> cfgAddr == ($past(ioWdata) & CFG_WRITE_MASK);
    endproperty
    a_addrWrite: assert property (p_addrWrite)
        else $error("address write lost");

    property p_addrRead;
        ioValid && !ioWrite && isAddrPort && fullDword
            |=> ioRdata == $past(cfgAddr) && ioClaim;
    endproperty
    a_addrRead: assert property (p_addrRead)
        else $error("address read wrong");

    property p_partialPass;
        ioValid && isAddrPort && !fullDword |=> $stable(cfgAddr) && cycleValid
            && cycleRoute == ROUTE_HUB_IO && !ioClaim;
    endproperty
    a_partialPass: assert property (p_partialPass)
        else $error("partial access misrouted");

    property p_reservedZero;
        cfgAddr[30:24] == 7'h00 && cfgAddr[1:0] == 2'b00;
    endproperty
    a_reservedZero: assert property (p_reservedZero)
        else $error("reserved bits set");

    property p_gateOff;
        ioValid && isDataPort && !cfgSpaceGate |=> cycleRoute == ROUTE_HUB_IO
            && cycleAddr[15:0] == $past(ioAddr);
    endproperty
    a_gateOff: assert property (p_gateOff)
        else $error("disabled window not passed");

    property p_busZeroHub;
        s_busZeroExternal |=> cycleValid && cycleRoute == ROUTE_HUB_T0
            && cycleAddr[15:2] == $past(cfgAddr[15:2]);
    endproperty
    a_busZeroHub: assert property (p_busZeroHub)
        else $error("bus zero not forwarded");

    property p_gfxType0;
        s_gfxType0 ##0 !devNum[4] |=> cycleRoute == ROUTE_GFX_T0
            && cycleAddr[31:16] == (IDSEL_ONE << $past(devNum[3:0]));
    endproperty
    a_gfxType0: assert property (p_gfxType0)
        else $error("wrong id select");

    property p_gfxAbort;
        s_gfxType0 ##0 devNum[4] |=> cycleAddr[31:16] == 16'h0000 && masterAbort
            ##1 (masterAbort || $past(masterAbortClr));
    endproperty
    a_gfxAbort: assert property (p_gfxAbort)
        else $error("abort not recorded");

    property p_gfxType1;
        s_cfgAccess ##0 busNum != BUS_ZERO && busNum > secondaryBus
            && busNum <= highestBusIndex |=> cycleRoute == ROUTE_GFX_T1
            && cycleAddr[23:0] == {$past(cfgAddr[23:2]), TYPE1_CODE};
    endproperty
    a_gfxType1: assert property (p_gfxType1)
        else $error("graphics type 1 misrouted");

    property p_hubType1;
        s_cfgAccess ##0 busNum != BUS_ZERO && (busNum < secondaryBus
            || busNum > highestBusIndex) |=> cycleRoute == ROUTE_HUB_T1;
    endproperty
    a_hubType1: assert property (p_hubType1)
        else $error("hub type 1 misrouted");

    property p_internal;
        s_cfgAccess ##0 busNum == BUS_ZERO && devNum <= DEV_HOST_GFX && devEnabled
            |=> (funcNum == FUNC_ZERO) == (internalSel != 2'b00) && !cycleValid;
    endproperty
    a_internal: assert property (p_internal)
        else $error("internal select wrong");

    property p_disabledDev;
        s_cfgAccess ##0 busNum == BUS_ZERO && devNum <= DEV_HOST_GFX && !devEnabled
            |=> cycleRoute == ROUTE_HUB_T0 && internalSel == 2'b00;
    endproperty
    a_disabledDev: assert property (p_disabledDev)
        else $error("disabled device not forwarded");

    property p_claimDword;
        ioValid && !(isAddrPort && fullDword) |=> !ioClaim;
    endproperty
    a_claimDword: assert property (p_claimDword)
        else $error("claim without dword access");

    property p_addrHeld;
        !addrWrite |=> $stable(cfgAddr);
    endproperty
    a_addrHeld: assert property (p_addrHeld)
        else $error("address register changed");

    property p_gateOffQuiet;
        ioValid && isDataPort && !cfgSpaceGate |=> internalSel == 2'b00;
    endproperty
    a_gateOffQuiet: assert property (p_gateOffQuiet)
        else $error("disabled gate reached device");

    property p_devCopy;
        s_cfgAccess ##0 busNum != secondaryBus
            |=> !cycleValid || cycleAddr[DEV_HI:DEV_LO] == $past(devNum);
    endproperty
    a_devCopy: assert property (p_devCopy)
        else $error("device field not copied");

    property p_funcCopy;
        s_cfgAccess |=> !cycleValid || cycleAddr[FUNC_HI:FUNC_LO] == $past(funcNum);
    endproperty
    a_funcCopy: assert property (p_funcCopy)
        else $error("function field not copied");

    property p_regCopy;
        s_cfgAccess |=> !cycleValid || cycleAddr[REG_HI:REG_LO] == $past(regNum);
    endproperty
    a_regCopy: assert property (p_regCopy)
        else $error("register field not copied");

    property p_internalSel;
        s_cfgAccess ##0 busNum == BUS_ZERO && devNum <= DEV_HOST_GFX && devEnabled
            && funcNum == FUNC_ZERO |=> internalSel == (2'b01 << $past(devNum[0]));
    endproperty
    a_internalSel: assert property (p_internalSel)
        else $error("wrong internal device selected");

    property p_dataWindow;
        s_cfgAccess |=> cycleRoute != ROUTE_HUB_IO && cycleRoute != ROUTE_NONE;
    endproperty
    a_dataWindow: assert property (p_dataWindow)
        else $error("window access not translated");

    property p_abortClear;
        masterAbortClr && !abortEvent |=> !masterAbort;
    endproperty
    a_abortClear: assert property (p_abortClear)
        else $error("abort status not cleared");
endmodule

/* File: bench/pcar_far_model.sv */
// Far-side model: graphics bridge bus window and a recorder of issued cycles
`timescale 1ns/1ps
module pcar_far_model #(
    parameter logic [7:0] SEC_BUS = 8'h05,
    parameter logic [7:0] TOP_BUS = 8'h08
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        cycleValid,
    input  wire logic [31:0] cycleAddr,
    output logic [7:0]       secondaryBus,
    output logic [7:0]       highestBusIndex,
    output logic [7:0]       cycleCount,
    output logic [31:0]      lastAddr
);
    // ==========================================
    // Bus window of the graphics bridge
    assign secondaryBus    = SEC_BUS;
    assign highestBusIndex = TOP_BUS;
    // ==========================================
    // Counts every cycle that arrives
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cycleCount <= 8'h00;
            lastAddr   <= 32'h0000_0000;
        end else if (cycleValid) begin
            cycleCount <= cycleCount + 8'h01;
            lastAddr   <= cycleAddr;
        end
    end
endmodule

/* File: bench/pci_config_address_router_bench.sv */
// Self-checking bench of the configuration address router
`timescale 1ns/1ps
module pci_config_address_router_bench;
    import pcar_pkg::*;
    typedef struct {
        logic [7:0]  bus;
        logic [4:0]  dev;
        logic [2:0]  fn;
        logic [5:0]  rg;
        pcar_route_e rt;
        logic [1:0]  sel;
        logic [31:0] addr;
    } pcar_row_s;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        ioValid = 1'b0;
    logic        ioWrite = 1'b0;
    logic [15:0] ioAddr = 16'h0000;
    logic [3:0]  ioByteEn = 4'h0;
    logic [31:0] ioWdata = 32'h0;
    logic        hostHubEnable = 1'b1;
    logic        hostGfxEnable = 1'b1;
    logic        masterAbortClr = 1'b0;
    logic [7:0]  secondaryBus, highestBusIndex, farCount;
    logic        ioAck, ioClaim, cycleValid, cycleWrite, masterAbort;
    logic [31:0] ioRdata, cycleAddr, cycleWdata, farAddr;
    logic [3:0]  cycleByteEn;
    logic [1:0]  internalSel;
    pcar_route_e cycleRoute;
    int          err_total = 0;
    int          n_checks = 0;
    logic        ext;
    pcar_row_s   rows [10] = '{
        '{8'h00, 5'h03, 3'h2, 6'h05, ROUTE_HUB_T0, 2'h0, 32'h0000_1a14},
        '{8'h05, 5'h02, 3'h1, 6'h03, ROUTE_GFX_T0, 2'h0, 32'h0004_010c},
        '{8'h07, 5'h09, 3'h4, 6'h0a, ROUTE_GFX_T1, 2'h0, 32'h0007_4c29},
        '{8'h08, 5'h00, 3'h0, 6'h00, ROUTE_GFX_T1, 2'h0, 32'h0008_0001},
        '{8'h09, 5'h01, 3'h0, 6'h01, ROUTE_HUB_T1, 2'h0, 32'h0009_0805},
        '{8'h03, 5'h1f, 3'h7, 6'h3f, ROUTE_HUB_T1, 2'h0, 32'h0003_fffd},
        '{8'h05, 5'h0f, 3'h0, 6'h00, ROUTE_GFX_T0, 2'h0, 32'h8000_0000},
        '{8'h00, 5'h00, 3'h0, 6'h02, ROUTE_INTERNAL, 2'h1, 32'h0},
        '{8'h00, 5'h01, 3'h0, 6'h00, ROUTE_INTERNAL, 2'h2, 32'h0},
        '{8'h00, 5'h01, 3'h3, 6'h00, ROUTE_IGNORED, 2'h0, 32'h0}
    };
    // ==========================================
    // Design, far side and clock
    pcar_config_router DUT (.clock(clock), .rst_n(rst_n), .ioValid(ioValid),
        .ioWrite(ioWrite), .ioAddr(ioAddr), .ioByteEn(ioByteEn), .ioWdata(ioWdata),
        .secondaryBus(secondaryBus), .highestBusIndex(highestBusIndex),
        .hostHubEnable(hostHubEnable), .hostGfxEnable(hostGfxEnable),
        .masterAbortClr(masterAbortClr), .ioAck(ioAck), .ioClaim(ioClaim),
        .ioRdata(ioRdata), .cycleValid(cycleValid), .cycleRoute(cycleRoute),
        .cycleAddr(cycleAddr), .cycleWrite(cycleWrite), .cycleByteEn(cycleByteEn),
        .cycleWdata(cycleWdata), .internalSel(internalSel), .masterAbort(masterAbort));
    pcar_far_model FAR (.clock(clock), .rst_n(rst_n), .cycleValid(cycleValid),
        .cycleAddr(cycleAddr), .secondaryBus(secondaryBus),
        .highestBusIndex(highestBusIndex), .cycleCount(farCount), .lastAddr(farAddr));
    initial forever #50 clock = ~clock;
    // ==========================================
    // Tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        @(posedge clock);
        ioValid  <= 1'b1;
        ioWrite  <= w;
        ioAddr   <= a;
        ioByteEn <= be;
        ioWdata  <= d;
        @(posedge clock);
        ioValid <= 1'b0;
        #1;
        chk("ack", 32'(ioAck), 32'h1);
    endtask
    task automatic cfg(input logic [7:0] b, input logic [4:0] dv, input logic [2:0] f,
                       input logic [5:0] r);
        io(1'b1, CFG_ADDR_PORT, FULL_DWORD, {1'b1, 7'h0, b, dv, f, r, 2'b00});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        final_report;
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        io(1'b0, CFG_ADDR_PORT, FULL_DWORD, 32'h0);
        chk("reset", ioRdata, CFG_ADDR_RESET);
        chk("claim", 32'(ioClaim), 32'h1);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            cfg(rows[i].bus, rows[i].dev, rows[i].fn, rows[i].rg);
            io(1'b0, CFG_DATA_PORT, FULL_DWORD, 32'h0);
            ext = (rows[i].addr != 32'h0);
            chk("route", 32'(cycleRoute), 32'(rows[i].rt));
            chk("sel", 32'(internalSel), 32'(rows[i].sel));
            chk("valid", 32'(cycleValid), 32'(ext));
            if (ext) chk("addr", cycleAddr, rows[i].addr);
        end
        chk("count", 32'(farCount), 32'h7);
        chk("faraddr", farAddr, 32'h8000_0000);
        $display("test table done");
        io(1'b1, CFG_ADDR_PORT, FULL_DWORD, 32'hffff_ffff);
        io(1'b0, CFG_ADDR_PORT, FULL_DWORD, 32'h0);
        chk("fixed", ioRdata, 32'h80ff_fffc);
        io(1'b1, CFG_ADDR_PORT, 4'h3, 32'h0);
        chk("ioroute", 32'(cycleRoute), 32'(ROUTE_HUB_IO));
        chk("ioaddr", cycleAddr, 32'h0000_0cf8);
        chk("noclaim", 32'(ioClaim), 32'h0);
        chk("iobe", 32'(cycleByteEn), 32'h3);
        io(1'b0, CFG_ADDR_PORT, FULL_DWORD, 32'h0);
        chk("kept", ioRdata, 32'h80ff_fffc);
        io(1'b1, CFG_ADDR_PORT, FULL_DWORD, 32'h0001_0800);
        io(1'b1, CFG_DATA_PORT, FULL_DWORD, 32'h1234_5678);
        chk("gateoff", 32'(cycleRoute), 32'(ROUTE_HUB_IO));
        chk("winaddr", cycleAddr, 32'h0000_0cfc);
        cfg(8'h09, 5'h02, 3'h0, 6'h04);
        io(1'b1, CFG_DATA_PORT, FULL_DWORD, 32'h1234_5678);
        chk("wr", 32'(cycleWrite), 32'h1);
        chk("wdata", cycleWdata, 32'h1234_5678);
        $display("test access kinds done");
        cfg(8'h05, 5'h10, 3'h0, 6'h00);
        io(1'b0, CFG_DATA_PORT, FULL_DWORD, 32'h0);
        chk("noidsel", cycleAddr, 32'h0);
        chk("abort", 32'(masterAbort), 32'h1);
        @(posedge clock);
        masterAbortClr <= 1'b1;
        @(posedge clock);
        masterAbortClr <= 1'b0;
        #1;
        chk("abortclr", 32'(masterAbort), 32'h0);
        @(posedge clock);
        hostHubEnable <= 1'b0;
        cfg(8'h00, 5'h00, 3'h0, 6'h01);
        io(1'b0, CFG_DATA_PORT, FULL_DWORD, 32'h0);
        chk("offdev", 32'(cycleRoute), 32'(ROUTE_HUB_T0));
        chk("offaddr", cycleAddr, 32'h0000_0004);
        $display("test abort and disabled device done");
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        io(1'b0, CFG_ADDR_PORT, FULL_DWORD, 32'h0);
        chk("rereset", ioRdata, CFG_ADDR_RESET);
        chk("reabort", 32'(masterAbort), 32'h0);
        $display("test mid-run reset done");
        final_report;
    end
endmodule
